// >>> design/apcr_defines.svh
// Purpose: offsets, field positions, reset values of the audio path control registers
// Assumes: byte-wide registers on the device's internal control-port register bus
// Notes:   included by the design modules and by the bench
`ifndef APCR_DEFINES_SVH
`define APCR_DEFINES_SVH

// ========================================================================
// register offsets
`define APCR_PATH_CONFIG_ADDR    8'h02
`define APCR_LEVEL_RAMP_ADDR     8'h03
`define APCR_LEFT_LEVEL_ADDR     8'h04
`define APCR_RIGHT_LEVEL_ADDR    8'h05

// ========================================================================
// field positions
`define APCR_HIGHPASS_SKIP_BIT   7
`define APCR_BOOST_HI            5
`define APCR_BOOST_LO            4
`define APCR_RATE_CLASS_BIT      3
`define APCR_FORMAT_HI           2
`define APCR_FORMAT_LO           0
`define APCR_FADE_BIT            7
`define APCR_MUTE_RIGHT_BIT      1
`define APCR_MUTE_LEFT_BIT       0

// ========================================================================
// writable masks and reset values
`define APCR_PATH_CONFIG_MASK    8'hBF
`define APCR_LEVEL_RAMP_MASK     8'h83
`define APCR_PATH_CONFIG_RST     8'h14
`define APCR_LEVEL_RAMP_RST      8'h80
`define APCR_LEVEL_RST           8'hCF
`define APCR_LEVEL_MUTE_BELOW    8'h07
`define APCR_LEVEL_ZERO_DB       8'hCF

`endif

// >>> design/apcr_pkg.sv
// Purpose: types shared by the audio path control register block
// Assumes: apcr_defines.svh holds the numbers
// Notes:   enumerations of boost and serial input format
package apcr_pkg;
    // ====================================================================
    // digital boost codes
    typedef enum logic [1:0] {
        APCR_BOOST_0DB,
        APCR_BOOST_6DB,
        APCR_BOOST_12DB,
        APCR_BOOST_18DB
    } apcr_boost_t;

    // ====================================================================
    // serial input format codes; codes above the left-justified one are reserved
    typedef enum logic [2:0] {
        APCR_FMT_RJ24,
        APCR_FMT_RJ20,
        APCR_FMT_RJ18,
        APCR_FMT_RJ16,
        APCR_FMT_I2S,
        APCR_FMT_LJ,
        APCR_FMT_RSV6,
        APCR_FMT_RSV7
    } apcr_format_t;
endpackage : apcr_pkg

// >>> design/apcr_level_decode.sv
// Purpose: converts an 8-bit volume code into gain in half-dB steps and a mute flag
// Assumes: one half-dB per code, zero dB at the reset code
// Notes:   outputs are registered
`timescale 1ns/1ps
`include "apcr_defines.svh"
module apcr_level_decode
    import apcr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [7:0]        code_i,
    output logic signed [8:0]      half_db_o,
    output logic                   mute_o
);
    // ====================================================================
    // gain in half-dB relative to the zero-dB code
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            half_db_o <= 9'sh000;
            mute_o    <= 1'b0;
        end else begin
            half_db_o <= $signed({1'b0, code_i}) - $signed({1'b0, `APCR_LEVEL_ZERO_DB});
            mute_o    <= (code_i < `APCR_LEVEL_MUTE_BELOW);
        end
    end

    AST_HALF_DB_STEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ##1 1'b1 |-> half_db_o == $signed({1'b0, $past(code_i)}) - 9'sh0CF)
        else $error("volume gain step wrong");
endmodule : apcr_level_decode

// >>> design/apcr_regs.sv
// Purpose: audio path, volume configuration and channel volume register bank
// Assumes: byte-wide register bus inside the device, same clock, writes in one cycle
// Notes:   reserved bits are held at zero and read as zero
`timescale 1ns/1ps
`include "apcr_defines.svh"
module apcr_regs
    import apcr_pkg::*;
(
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_B_I,
    input  wire logic [7:0]        REG_ADDR_I,
    input  wire logic              REG_WR_I,
    input  wire logic [7:0]        REG_WDATA_I,
    input  wire logic              REG_RD_I,
    output logic [7:0]             REG_RDATA_O,
    output logic                   HIGHPASS_SKIP_O,
    output logic [1:0]             BOOST_O,
    output logic [4:0]             BOOST_DB_O,
    output logic                   RATE_CLASS_SELECT_O,
    output logic [2:0]             FORMAT_O,
    output logic                   FORMAT_RIGHT_JUST_O,
    output logic [4:0]             WORD_LEN_O,
    output logic                   FORMAT_I2S_O,
    output logic                   FORMAT_LEFT_JUST_O,
    output logic                   FADE_EN_O,
    output logic                   MUTE_LEFT_O,
    output logic                   MUTE_RIGHT_O,
    output logic signed [8:0]      LEFT_HALF_DB_O,
    output logic signed [8:0]      RIGHT_HALF_DB_O
);
    logic [7:0]   path_config;
    logic [7:0]   level_ramp_config;
    logic [7:0]   left_level;
    logic [7:0]   right_level;
    logic         left_code_mute;
    logic         right_code_mute;
    apcr_format_t fmt;

    // ====================================================================
    // returns the written value with reserved bits forced to zero
    function automatic logic [7:0] apcr_masked(input logic [7:0] d, input logic [7:0] m);
        apcr_masked = d & m;
    endfunction : apcr_masked

    // ====================================================================
    // register writes
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            path_config       <= `APCR_PATH_CONFIG_RST;
            level_ramp_config <= `APCR_LEVEL_RAMP_RST;
            left_level        <= `APCR_LEVEL_RST;
            right_level       <= `APCR_LEVEL_RST;
        end else if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `APCR_PATH_CONFIG_ADDR: begin
                    path_config <= apcr_masked(REG_WDATA_I, `APCR_PATH_CONFIG_MASK);
                end
                `APCR_LEVEL_RAMP_ADDR: begin
                    level_ramp_config <= apcr_masked(REG_WDATA_I, `APCR_LEVEL_RAMP_MASK);
                end
                `APCR_LEFT_LEVEL_ADDR: begin
                    left_level <= REG_WDATA_I;
                end
                `APCR_RIGHT_LEVEL_ADDR: begin
                    right_level <= REG_WDATA_I;
                end
                default: begin
                end
            endcase
        end
    end

    // ====================================================================
    // read data, registered; unmapped offsets read zero
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `APCR_PATH_CONFIG_ADDR: REG_RDATA_O <= path_config;
                `APCR_LEVEL_RAMP_ADDR:  REG_RDATA_O <= level_ramp_config;
                `APCR_LEFT_LEVEL_ADDR:  REG_RDATA_O <= left_level;
                `APCR_RIGHT_LEVEL_ADDR: REG_RDATA_O <= right_level;
                default:                REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    // ====================================================================
    // gain decode for both channels
    apcr_level_decode u_left_dec (
        .clk_i     (SYS_CLK_I),
        .rst_b_i   (RST_B_I),
        .code_i    (left_level),
        .half_db_o (LEFT_HALF_DB_O),
        .mute_o    (left_code_mute)
    );
    apcr_level_decode u_right_dec (
        .clk_i     (SYS_CLK_I),
        .rst_b_i   (RST_B_I),
        .code_i    (right_level),
        .half_db_o (RIGHT_HALF_DB_O),
        .mute_o    (right_code_mute)
    );

    assign fmt = apcr_format_t'(path_config[`APCR_FORMAT_HI:`APCR_FORMAT_LO]);

    // ====================================================================
    // path controls toward the audio datapath, registered
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            HIGHPASS_SKIP_O     <= 1'b0;
            BOOST_O             <= 2'h1;
            BOOST_DB_O          <= 5'h06;
            RATE_CLASS_SELECT_O <= 1'b0;
            FORMAT_O            <= 3'h4;
        end else begin
            HIGHPASS_SKIP_O     <= path_config[`APCR_HIGHPASS_SKIP_BIT];
            BOOST_O             <= path_config[`APCR_BOOST_HI:`APCR_BOOST_LO];
            BOOST_DB_O          <= 5'(5'h06 * path_config[`APCR_BOOST_HI:`APCR_BOOST_LO]);
            RATE_CLASS_SELECT_O <= path_config[`APCR_RATE_CLASS_BIT];
            FORMAT_O            <= path_config[`APCR_FORMAT_HI:`APCR_FORMAT_LO];
        end
    end

    // ====================================================================
    // serial format decode; reserved codes select nothing
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            FORMAT_RIGHT_JUST_O <= 1'b0;
            WORD_LEN_O          <= 5'h18;
            FORMAT_I2S_O        <= 1'b1;
            FORMAT_LEFT_JUST_O  <= 1'b0;
        end else begin
            FORMAT_RIGHT_JUST_O <= (fmt <= APCR_FMT_RJ16);
            FORMAT_I2S_O        <= (fmt == APCR_FMT_I2S);
            FORMAT_LEFT_JUST_O  <= (fmt == APCR_FMT_LJ);
            unique case (fmt)
                APCR_FMT_RJ24: WORD_LEN_O <= 5'h18;
                APCR_FMT_RJ20: WORD_LEN_O <= 5'h14;
                APCR_FMT_RJ18: WORD_LEN_O <= 5'h12;
                APCR_FMT_RJ16: WORD_LEN_O <= 5'h10;
                default:       WORD_LEN_O <= 5'h18;
            endcase
        end
    end

    // ====================================================================
    // fade and mute controls; a muted channel drives 50/50 duty downstream
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            FADE_EN_O    <= 1'b1;
            MUTE_LEFT_O  <= 1'b0;
            MUTE_RIGHT_O <= 1'b0;
        end else begin
            FADE_EN_O    <= level_ramp_config[`APCR_FADE_BIT];
            MUTE_LEFT_O  <= level_ramp_config[`APCR_MUTE_LEFT_BIT] | left_code_mute;
            MUTE_RIGHT_O <= level_ramp_config[`APCR_MUTE_RIGHT_BIT] | right_code_mute;
        end
    end

    // ====================================================================
    // checks
    sequence seq_wr_path;
        REG_WR_I && REG_ADDR_I == `APCR_PATH_CONFIG_ADDR;
    endsequence
    sequence seq_wr_ramp;
        REG_WR_I && REG_ADDR_I == `APCR_LEVEL_RAMP_ADDR;
    endsequence

    AST_HIGHPASS_SKIP: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        seq_wr_path ##1 !REG_WR_I |=> HIGHPASS_SKIP_O == $past(REG_WDATA_I[7], 2))
        else $error("highpass skip not following write");
    AST_BOOST_DB: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ##1 1'b1 |-> BOOST_DB_O == 5'(5'h06 * $past(path_config[5:4])))
        else $error("boost gain wrong");
    AST_RATE_CLASS: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ##1 1'b1 |-> RATE_CLASS_SELECT_O == $past(path_config[3]))
        else $error("rate class wrong");
    AST_RJ_LEN: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ##1 $past(path_config[2:0]) == 3'h2 |-> FORMAT_RIGHT_JUST_O && WORD_LEN_O == 5'h12)
        else $error("right justified length wrong");
    AST_I2S_LJ: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ##1 1'b1 |-> FORMAT_I2S_O == ($past(path_config[2:0]) == 3'h4)
            && FORMAT_LEFT_JUST_O == ($past(path_config[2:0]) == 3'h5))
        else $error("i2s or left justified select wrong");
    AST_FADE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        seq_wr_ramp ##1 !REG_WR_I |=> FADE_EN_O == $past(REG_WDATA_I[7], 2))
        else $error("fade enable not following write");
    AST_MUTE_R: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        $rose(level_ramp_config[1]) |=> MUTE_RIGHT_O)
        else $error("right mute late");
    AST_MUTE_L: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        $rose(level_ramp_config[0]) |=> MUTE_LEFT_O)
        else $error("left mute late");
    AST_LOW_CODE_MUTE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (left_level < `APCR_LEVEL_MUTE_BELOW) [*2] |=> MUTE_LEFT_O)
        else $error("low left code not muting");
    AST_RSV_ZERO: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        path_config[6] == 1'b0 && level_ramp_config[6:2] == 5'h00)
        else $error("reserved bit set");
endmodule : apcr_regs

// >>> test/apcr_host_model.sv
// Purpose: host controller model that drives the register strobes of the bank
// Assumes: strobes change at the falling edge and are taken at the next rising edge
// Notes:   data is tidied to legal values unless a raw write is commanded
`timescale 1ns/1ps
`include "apcr_defines.svh"
module apcr_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic [7:0]      addr_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o,
    output logic            rd_o
);
    // ====================================================================
    // idle bus at time zero
    initial begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        wdata_o = 8'h00;
        rd_o    = 1'b0;
    end

    // one write strobe; legal hosts clear reserved bits and skip reserved formats
    task automatic host_write(input logic [7:0] a, input logic [7:0] d, input bit raw);
        logic [7:0] v;
        v = d;
        if (!raw && a == `APCR_PATH_CONFIG_ADDR) begin
            v = v & `APCR_PATH_CONFIG_MASK;
            if (v[2:0] > 3'h5) v[2:0] = 3'h4;
        end
        if (!raw && a == `APCR_LEVEL_RAMP_ADDR) v = v & `APCR_LEVEL_RAMP_MASK;
        @(negedge clk_i);
        addr_o  <= a;
        wdata_o <= v;
        wr_o    <= 1'b1;
        @(negedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~v; // released data must not look valid
    endtask : host_write

    // one read strobe; data taken one and a half cycles after the read edge
    task automatic host_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(negedge clk_i);
        rd_o   <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask : host_read
endmodule : apcr_host_model

// >>> test/tb_top.sv
// Purpose: self-checking bench of the audio path control register bank
// Assumes: derived outputs settle within four cycles of the write edge
// Notes:   all bus cycles go through the host model tasks
`timescale 1ns/1ps
`include "apcr_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
    import apcr_pkg::*;
;
    logic              sys_clk, rst_b, wr, rd, hp, rate, fade, mute_l, mute_r, rj, i2s, lj;
    logic [7:0]        addr, wdata, rdata, v, r;
    logic [1:0]        boost;
    logic [4:0]        boost_db, word_len;
    logic [2:0]        fmt, c;
    logic signed [8:0] left_db, right_db, e;
    int                n_errors, n_compared;
    logic [4:0]        wl_tab [8] = '{5'h18, 5'h14, 5'h12, 5'h10, 5'h18, 5'h18, 5'h18, 5'h18};
    logic [7:0]        ramp_tab [4] = '{8'h00, 8'h01, 8'h02, 8'h83};
    logic [7:0]        lvl_tab [7] = '{8'hFF, 8'hFE, 8'hCF, 8'h08, 8'h07, 8'h06, 8'h00};

    // ====================================================================
    // clock, host and device
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    apcr_host_model i_host (.clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd));
    apcr_regs i_dut (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .HIGHPASS_SKIP_O(hp),
        .BOOST_O(boost), .BOOST_DB_O(boost_db), .RATE_CLASS_SELECT_O(rate), .FORMAT_O(fmt),
        .FORMAT_RIGHT_JUST_O(rj), .WORD_LEN_O(word_len), .FORMAT_I2S_O(i2s),
        .FORMAT_LEFT_JUST_O(lj), .FADE_EN_O(fade), .MUTE_LEFT_O(mute_l),
        .MUTE_RIGHT_O(mute_r), .LEFT_HALF_DB_O(left_db), .RIGHT_HALF_DB_O(right_db));

    // verdict and end of run
    task automatic complete_run();
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // reset held for two cycles, then reset values read back
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        i_host.host_read(`APCR_PATH_CONFIG_ADDR, r);
        `CHK(r, 8'h14)
        i_host.host_read(`APCR_LEVEL_RAMP_ADDR, r);
        `CHK(r, 8'h80)
        i_host.host_read(`APCR_LEFT_LEVEL_ADDR, r);
        `CHK(r, 8'hCF)
        i_host.host_read(`APCR_RIGHT_LEVEL_ADDR, r);
        `CHK(r, 8'hCF)
    endtask : do_reset

    // watchdog against a hung run
    initial begin
        #500000;
        n_errors++;
        complete_run();
    end

    // ====================================================================
    // main sequence
    initial begin
        n_errors = 0;
        n_compared = 0;
        do_reset();
        `CHK({hp, boost, boost_db, rate}, {1'b0, 2'h1, 5'h06, 1'b0})
        `CHK({fmt, i2s, fade, mute_l, mute_r}, {3'h4, 1'b1, 1'b1, 1'b0, 1'b0})
        `CHK({left_db, right_db}, 18'h00000)
        // every legal format code, boost code and both values of the single bits
        for (int i = 0; i < 6; i++) begin
            c = i[2:0];
            v = {c[0], 1'b0, c[1:0], c[1], c};
            i_host.host_write(`APCR_PATH_CONFIG_ADDR, v, 1'b0);
            i_host.host_read(`APCR_PATH_CONFIG_ADDR, r);
            `CHK(r, v)
            `CHK(hp, c[0])
            `CHK({boost, boost_db}, {c[1:0], 5'(c[1:0]) * 5'h06})
            `CHK(rate, c[1])
            `CHK({fmt, rj, word_len}, {c, c < 3'h4, wl_tab[c]})
            `CHK({i2s, lj}, {c == 3'h4, c == 3'h5})
        end
        // fade and both mute bits
        for (int i = 0; i < 4; i++) begin
            i_host.host_write(`APCR_LEVEL_RAMP_ADDR, ramp_tab[i], 1'b0);
            repeat (4) @(negedge sys_clk);
            `CHK(fade, ramp_tab[i][7])
            `CHK(mute_r, ramp_tab[i][1])
            `CHK(mute_l, ramp_tab[i][0])
        end
        i_host.host_write(`APCR_LEVEL_RAMP_ADDR, 8'h80, 1'b0);
        // gain points of both channels, mute threshold edges included
        for (int i = 0; i < 7; i++) begin
            i_host.host_write(`APCR_LEFT_LEVEL_ADDR, lvl_tab[i], 1'b0);
            i_host.host_write(`APCR_RIGHT_LEVEL_ADDR, lvl_tab[i], 1'b0);
            repeat (4) @(negedge sys_clk);
            e = {1'b0, lvl_tab[i]} - 9'h0CF;
            `CHK({left_db, mute_l}, {e, lvl_tab[i] < 8'h07})
            `CHK({right_db, mute_r}, {e, lvl_tab[i] < 8'h07})
            i_host.host_read(`APCR_LEFT_LEVEL_ADDR, r);
            `CHK(r, lvl_tab[i])
        end
        // reserved bits and a reserved format code written on purpose
        i_host.host_write(`APCR_PATH_CONFIG_ADDR, 8'hFF, 1'b1);
        i_host.host_read(`APCR_PATH_CONFIG_ADDR, r);
        `CHK(r, 8'hBF)
        `CHK({rj, i2s, lj}, 3'h0)
        i_host.host_write(`APCR_LEVEL_RAMP_ADDR, 8'hFF, 1'b1);
        i_host.host_read(`APCR_LEVEL_RAMP_ADDR, r);
        `CHK(r, 8'h83)
        // unmapped offset neither stores nor disturbs
        i_host.host_write(8'h10, 8'hAA, 1'b1);
        i_host.host_read(8'h10, r);
        `CHK(r, 8'h00)
        i_host.host_read(`APCR_PATH_CONFIG_ADDR, r);
        `CHK(r, 8'hBF)
        // second reset in mid-run restores defaults
        do_reset();
        complete_run();
    end
endmodule : tb_top
